// ===== include/pin_control_pkg.sv
package pin_control_pkg;
  // pin count and register map
  localparam int PIN_COUNT = 7;
  localparam logic [15:0] CORE_CONTROL_ADDR = 16'h0009;
  localparam logic [15:0] BYPASS_PATH_ADDR = 16'h002A;
  localparam logic [15:0] BYPASS_GAIN_0_ADDR = 16'h002B;
  localparam logic [15:0] BYPASS_GAIN_1_ADDR = 16'h002C;
  localparam logic [15:0] PIN_FUNCTION_BASE = 16'h0038;
  localparam logic [15:0] PIN_FUNCTION_LAST = 16'h003E;
  localparam logic [15:0] ADC_VOLUME_ADDR = 16'h0060;
  localparam logic [15:0] DAC_VOLUME_ADDR = 16'h0061;
  localparam logic [15:0] BUTTON_START_ADDR = 16'h0062;
  localparam logic [15:0] BUTTON_TARGET_ADDR = 16'h0063;
  localparam logic [15:0] PIN_STATUS_ADDR = 16'h0064;
  localparam logic [15:0] MODE_STATUS_ADDR = 16'h0065;
  // field positions
  localparam int FN_CODE_MSB = 3;
  localparam int MUTE_ADC_BIT = 4;
  localparam int MUTE_DAC_BIT = 5;
  localparam int BANK_SEL_LSB = 5;
  localparam int BANK_SEL_MSB = 6;
  localparam int ZERO_STATE_BIT = 7;
  localparam int TARGET_ADC_BIT = 0;
  localparam int TARGET_DAC_BIT = 1;
  localparam int ROUTE_MSB = 3;
  // pin functions
  typedef enum logic [3:0] {
    FN_DEFAULT, FN_VOLUME_UP, FN_VOLUME_DOWN, FN_LIMITER, FN_BANK, FN_MUTE, FN_BYPASS
  } pin_function_type;
  typedef enum logic [1:0] {BTN_IDLE, BTN_WAIT, BTN_REPEAT} button_state_type;
  // reset values
  localparam logic [7:0] PIN_FUNCTION_RESET = 8'h00;
  localparam logic [7:0] PIN_ONE_RESET = 8'h01;
  localparam logic [7:0] PIN_SIX_RESET = 8'h02;
  localparam logic [7:0] CORE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYPASS_PATH_RESET = 8'h00;
  localparam logic [7:0] BYPASS_GAIN_RESET = 8'h00;
  localparam logic [7:0] VOLUME_RESET = 8'h00;
  localparam logic [7:0] START_LEVEL_RESET = 8'h00;
  localparam logic [1:0] TARGET_RESET = 2'h0;
  // attenuation code of -95.625 dB, 0.375 dB per step
  localparam logic [7:0] MUTE_LEVEL = 8'hFF;
  localparam logic [7:0] LOUDEST_LEVEL = 8'h00;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int RAMP_STEP_NS = 1000;
  localparam int RAMP_STEP_CYCLES = (RAMP_STEP_NS * CLK_MHZ + 999) / 1000;
  localparam int BUTTON_HOLD_MS = 500;
  localparam int BUTTON_REPEAT_MS = 50;
  localparam int BUTTON_HOLD_CYCLES = BUTTON_HOLD_MS * CLK_MHZ * 1000;
  localparam int BUTTON_REPEAT_CYCLES = BUTTON_REPEAT_MS * CLK_MHZ * 1000;
endpackage

// ===== logic/pin_sync.sv
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // raw pin and synchronised views
  input wire logic pin_raw,
  output logic level_q,
  output logic rise_q
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= RESET_LEVEL;
      sync_q <= RESET_LEVEL;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= RESET_LEVEL;
      rise_q <= 1'b0;
    end else begin
      level_q <= sync_q;
      rise_q <= sync_q & ~level_q;
    end
  end
endmodule

// ===== logic/volume_ramp.sv
`timescale 1ns/10ps
module volume_ramp #(
  parameter logic [7:0] RESET_LEVEL = 8'h00
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // step enable and goal
  input wire logic step_en,
  input wire logic [7:0] target,
  // present attenuation
  output logic [7:0] level_q
);
  // one code per step toward the goal, so a path change never jumps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q <= RESET_LEVEL;
    end else if (step_en) begin
      if (level_q < target) begin
        level_q <= level_q + 8'h01;
      end else if (level_q > target) begin
        level_q <= level_q - 8'h01;
      end
    end
  end
endmodule

// ===== logic/multipurpose_pin_control.sv
`timescale 1ns/10ps
// Overview of operation
// - Seven pins each pick default role or a control function via byte registers 0x38-0x3E.
// - After reset every pin other than pins one and six is an input in its default role.
// - Pin one defaults to volume up, pin six to volume down, any pin may take either role.
// - Each button rising edge steps volume unless both rise in one cycle, holding one button ramps, both held never ramps.
// - Entering button mode loads the volume from the start level field.
// - Volume register writes are ignored while buttons own that volume.
// - A low limiter pin forces minimum-gain compression, release restores normal limiting.
// - A bank pin high selects bank A and low selects bank B.
// - A zero-on-switch bit decides whether data memory is cleared on a bank change.
// - A low mute pin mutes the ADC and/or DAC chosen in its function register.
// - A low bypass pin routes ADC0 and ADC1 to the DACs as the path register sets.
// - In bypass the bypass path gain comes from the two bypass gain registers.
// - Bypass entry ramps DAC volume down to -95.625 dB while bypass volume ramps up.
// - Bypass works whatever source feeds the ADCs.
module multipurpose_pin_control import pin_control_pkg::*; #(
  parameter int HOLD_CYCLES = BUTTON_HOLD_CYCLES,
  parameter int REPEAT_CYCLES = BUTTON_REPEAT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // multipurpose pins
  input wire logic [PIN_COUNT-1:0] multipurpose_pin,
  // control port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata_q,
  // volume controls
  output logic [7:0] adc_attenuation_q,
  output logic [7:0] dac_attenuation_q,
  output logic [7:0] bypass_attenuation_0_q,
  output logic [7:0] bypass_attenuation_1_q,
  // processing controls
  output logic limiter_force_q,
  output logic bank_b_active_q,
  output logic data_clear_q,
  output logic adc_mute_q,
  output logic dac_mute_q,
  output logic bypass_active_q,
  output logic [ROUTE_MSB:0] bypass_route_q
);
  logic [7:0] pin_function_q [PIN_COUNT];
  logic [7:0] core_control_q;
  logic [7:0] bypass_path_q;
  logic [7:0] bypass_gain_q [2];
  logic [7:0] adc_volume_q;
  logic [7:0] dac_volume_q;
  logic [7:0] start_level_q;
  logic [1:0] target_q;
  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_rise;
  logic up_rise, down_rise, up_held, down_held, button_pin;
  logic limiter_low, bank_pin, bank_low, mute_adc_d, mute_dac_d, bypass_low;
  logic pb_mode, pb_mode_q, pb_entry, repeat_step, step_up, step_down, bank_b_d;
  logic [7:0] pb_level_q;
  logic [7:0] dac_base;
  logic [7:0] dac_target;
  button_state_type button_state_q;
  logic [31:0] hold_count_q;
  logic [15:0] ramp_count_q;
  logic ramp_tick_q;
  logic [7:0] bypass_level [2];

  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
    pin_sync #(.RESET_LEVEL(1'b1)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin_raw(multipurpose_pin[i]),
      .level_q(pin_level[i]),
      .rise_q(pin_rise[i])
    );
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        pin_function_q[i] <= PIN_FUNCTION_RESET;
      end
      pin_function_q[1] <= PIN_ONE_RESET;
      pin_function_q[6] <= PIN_SIX_RESET;
    end else if (reg_write) begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (reg_addr == PIN_FUNCTION_BASE + 16'(i)) begin
          pin_function_q[i] <= reg_wdata;
        end
      end
    end
  end

  // remaining writable registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_control_q <= CORE_CONTROL_RESET;
      bypass_path_q <= BYPASS_PATH_RESET;
      bypass_gain_q[0] <= BYPASS_GAIN_RESET;
      bypass_gain_q[1] <= BYPASS_GAIN_RESET;
      adc_volume_q <= VOLUME_RESET;
      dac_volume_q <= VOLUME_RESET;
      start_level_q <= START_LEVEL_RESET;
      target_q <= TARGET_RESET;
    end else if (reg_write) begin
      unique case (reg_addr)
        CORE_CONTROL_ADDR: core_control_q <= reg_wdata;
        BYPASS_PATH_ADDR: bypass_path_q <= reg_wdata;
        BYPASS_GAIN_0_ADDR: bypass_gain_q[0] <= reg_wdata;
        BYPASS_GAIN_1_ADDR: bypass_gain_q[1] <= reg_wdata;
        ADC_VOLUME_ADDR: begin
          if (!(pb_mode && target_q[TARGET_ADC_BIT])) begin
            adc_volume_q <= reg_wdata;
          end
        end
        DAC_VOLUME_ADDR: begin
          if (!(pb_mode && target_q[TARGET_DAC_BIT])) begin
            dac_volume_q <= reg_wdata;
          end
        end
        BUTTON_START_ADDR: start_level_q <= reg_wdata;
        BUTTON_TARGET_ADDR: target_q <= reg_wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // register reads, unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
      reg_rdata_q <= 8'h00;
      unique case (reg_addr)
        CORE_CONTROL_ADDR: reg_rdata_q <= core_control_q;
        BYPASS_PATH_ADDR: reg_rdata_q <= bypass_path_q;
        BYPASS_GAIN_0_ADDR: reg_rdata_q <= bypass_gain_q[0];
        BYPASS_GAIN_1_ADDR: reg_rdata_q <= bypass_gain_q[1];
        ADC_VOLUME_ADDR: reg_rdata_q <= adc_volume_q;
        DAC_VOLUME_ADDR: reg_rdata_q <= dac_volume_q;
        BUTTON_START_ADDR: reg_rdata_q <= start_level_q;
        BUTTON_TARGET_ADDR: reg_rdata_q <= {6'h00, target_q};
        PIN_STATUS_ADDR: reg_rdata_q <= {1'b0, pin_level};
        MODE_STATUS_ADDR: reg_rdata_q <= {2'h0, pb_mode_q, dac_mute_q, adc_mute_q,
                                          limiter_force_q, bypass_active_q, bank_b_active_q};
        default: begin
          for (int i = 0; i < PIN_COUNT; i++) begin
            if (reg_addr == PIN_FUNCTION_BASE + 16'(i)) begin
              reg_rdata_q <= pin_function_q[i];
            end
          end
        end
      endcase
    end
  end

  // pin function decode
  always_comb begin
    logic [3:0] fn;
    fn = 4'h0;
    up_rise = 1'b0;
    down_rise = 1'b0;
    up_held = 1'b0;
    down_held = 1'b0;
    button_pin = 1'b0;
    limiter_low = 1'b0;
    bank_pin = 1'b0;
    bank_low = 1'b0;
    mute_adc_d = 1'b0;
    mute_dac_d = 1'b0;
    bypass_low = 1'b0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      fn = pin_function_q[i][FN_CODE_MSB:0];
      // any pin may be a button
      if (fn == FN_VOLUME_UP) begin
        up_rise = up_rise | pin_rise[i];
        up_held = up_held | pin_level[i];
        button_pin = 1'b1;
      end
      if (fn == FN_VOLUME_DOWN) begin
        down_rise = down_rise | pin_rise[i];
        down_held = down_held | pin_level[i];
        button_pin = 1'b1;
      end
      if (fn == FN_LIMITER && !pin_level[i]) begin
        limiter_low = 1'b1;
      end
      if (fn == FN_BANK) begin
        bank_pin = 1'b1;
        bank_low = bank_low | ~pin_level[i];
      end
      if (fn == FN_MUTE && !pin_level[i]) begin
        mute_adc_d = mute_adc_d | pin_function_q[i][MUTE_ADC_BIT];
        mute_dac_d = mute_dac_d | pin_function_q[i][MUTE_DAC_BIT];
      end
      if (fn == FN_BYPASS && !pin_level[i]) begin
        bypass_low = 1'b1;
      end
    end
  end

  assign pb_mode = button_pin && (target_q != 2'h0);
  assign pb_entry = pb_mode && !pb_mode_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      button_state_q <= BTN_IDLE;
      hold_count_q <= 32'h0000_0000;
    end else begin
      unique case (button_state_q)
        BTN_IDLE: begin
          hold_count_q <= 32'h0000_0000;
          if (up_held ^ down_held) begin
            button_state_q <= BTN_WAIT;
          end
        end
        BTN_WAIT: begin
          if (!(up_held ^ down_held)) begin
            button_state_q <= BTN_IDLE;
          end else if (hold_count_q == 32'(HOLD_CYCLES - 1)) begin
            button_state_q <= BTN_REPEAT;
            hold_count_q <= 32'h0000_0000;
          end else begin
            hold_count_q <= hold_count_q + 32'h0000_0001;
          end
        end
        BTN_REPEAT: begin
          if (!(up_held ^ down_held)) begin
            button_state_q <= BTN_IDLE;
          end else if (hold_count_q == 32'(REPEAT_CYCLES - 1)) begin
            hold_count_q <= 32'h0000_0000;
          end else begin
            hold_count_q <= hold_count_q + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  assign repeat_step = (button_state_q == BTN_REPEAT) && (up_held ^ down_held)
                       && (hold_count_q == 32'(REPEAT_CYCLES - 1));
  assign step_up = up_rise | (repeat_step & up_held);
  assign step_down = down_rise | (repeat_step & down_held);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pb_mode_q <= 1'b0;
      pb_level_q <= START_LEVEL_RESET;
    end else begin
      pb_mode_q <= pb_mode;
      if (pb_entry) begin
        pb_level_q <= start_level_q;
      end else if (pb_mode) begin
        // one step per edge or repeat
        if (step_up && !step_down && pb_level_q != LOUDEST_LEVEL) begin
          pb_level_q <= pb_level_q - 8'h01;
        end else if (step_down && !step_up && pb_level_q != MUTE_LEVEL) begin
          pb_level_q <= pb_level_q + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      adc_attenuation_q <= VOLUME_RESET;
    end else begin
      adc_attenuation_q <= (pb_mode_q && target_q[TARGET_ADC_BIT]) ? pb_level_q : adc_volume_q;
    end
  end
  assign dac_base = (pb_mode_q && target_q[TARGET_DAC_BIT]) ? pb_level_q : dac_volume_q;

  // limiter, mute and bypass levels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      limiter_force_q <= 1'b0;
      adc_mute_q <= 1'b0;
      dac_mute_q <= 1'b0;
      bypass_active_q <= 1'b0;
      bypass_route_q <= '0;
    end else begin
      limiter_force_q <= limiter_low;
      adc_mute_q <= mute_adc_d;
      dac_mute_q <= mute_dac_d;
      bypass_active_q <= bypass_low;
      bypass_route_q <= bypass_low ? bypass_path_q[ROUTE_MSB:0] : '0;
    end
  end

  assign bank_b_d = bank_pin ? bank_low : (core_control_q[BANK_SEL_MSB:BANK_SEL_LSB] != 2'h0);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_b_active_q <= 1'b0;
      data_clear_q <= 1'b0;
    end else begin
      bank_b_active_q <= bank_b_d;
      data_clear_q <= (bank_b_d != bank_b_active_q) && core_control_q[ZERO_STATE_BIT];
    end
  end

  // ramp step divider
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ramp_count_q <= 16'h0000;
      ramp_tick_q <= 1'b0;
    end else begin
      ramp_tick_q <= (ramp_count_q == 16'(RAMP_STEP_CYCLES - 1));
      if (ramp_count_q == 16'(RAMP_STEP_CYCLES - 1)) begin
        ramp_count_q <= 16'h0000;
      end else begin
        ramp_count_q <= ramp_count_q + 16'h0001;
      end
    end
  end

  // normal DAC volume ramps to mute in bypass
  assign dac_target = bypass_active_q ? MUTE_LEVEL : dac_base;
  volume_ramp #(.RESET_LEVEL(VOLUME_RESET)) u_dac_ramp (
    .clk(clk),
    .reset_n(reset_n),
    .step_en(ramp_tick_q),
    .target(dac_target),
    .level_q(dac_attenuation_q)
  );

  // bypass gain ramps up from mute
  for (genvar k = 0; k < 2; k++) begin : g_bypass_ramp
    volume_ramp #(.RESET_LEVEL(MUTE_LEVEL)) u_ramp (
      .clk(clk),
      .reset_n(reset_n),
      .step_en(ramp_tick_q),
      .target(bypass_active_q ? bypass_gain_q[k] : MUTE_LEVEL),
      .level_q(bypass_level[k])
    );
  end
  assign bypass_attenuation_0_q = bypass_level[0];
  assign bypass_attenuation_1_q = bypass_level[1];

  button_up_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    pb_mode_q && pb_mode && step_up && !step_down && pb_level_q != LOUDEST_LEVEL
    |=> pb_level_q == $past(pb_level_q) - 8'h01) else $error("button up step missed");
  both_held_a: assert property (@(posedge clk) disable iff (!reset_n)
    up_held && down_held |-> !repeat_step) else $error("ramp with both buttons held");
  start_level_a: assert property (@(posedge clk) disable iff (!reset_n)
    pb_entry |=> pb_level_q == $past(start_level_q)) else $error("start level not loaded");
  volume_write_block_a: assert property (@(posedge clk) disable iff (!reset_n)
    reg_write && reg_addr == ADC_VOLUME_ADDR && pb_mode && target_q[TARGET_ADC_BIT]
    |=> $stable(adc_volume_q)) else $error("adc volume written under button control");
  limiter_force_a: assert property (@(posedge clk) disable iff (!reset_n)
    limiter_low |=> limiter_force_q) else $error("limiter force not applied");
  bank_a_high_a: assert property (@(posedge clk) disable iff (!reset_n)
    bank_pin && !bank_low |=> !bank_b_active_q)
    else $error("bank A not selected");
  zero_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    bank_b_d != bank_b_active_q |=> data_clear_q == $past(core_control_q[ZERO_STATE_BIT]))
    else $error("data clear wrong on bank change");
  dac_mute_a: assert property (@(posedge clk) disable iff (!reset_n)
    mute_dac_d |=> dac_mute_q) else $error("dac mute not applied");
  bypass_route_a: assert property (@(posedge clk) disable iff (!reset_n)
    bypass_low |=> bypass_active_q && bypass_route_q == $past(bypass_path_q[ROUTE_MSB:0]))
    else $error("bypass route wrong");
  dac_ramp_down_a: assert property (@(posedge clk) disable iff (!reset_n)
    bypass_active_q && $past(bypass_active_q) |-> dac_attenuation_q >= $past(dac_attenuation_q))
    else $error("dac volume rose during bypass");
  bypass_entry_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(bypass_active_q));
  button_step_c: cover property (@(posedge clk) disable iff (!reset_n) pb_mode_q && step_up);
  bank_clear_c: cover property (@(posedge clk) disable iff (!reset_n) data_clear_q);
endmodule

// ===== bench/switch_model.sv
`timescale 1ns/10ps
// push-button switches and control lines on the multipurpose pins
module switch_model import pin_control_pkg::*; (
  // switch state
  input wire logic [PIN_COUNT-1:0] closed,
  input wire logic [PIN_COUNT-1:0] active_high,
  // pin lines
  output logic [PIN_COUNT-1:0] multipurpose_pin
);
  // closed switch drives its active level, an open line rests on its pull
  assign multipurpose_pin = ~(closed ^ active_high);
endmodule

// ===== bench/multipurpose_pin_control_test.sv
`timescale 1ns/10ps
module multipurpose_pin_control_test import pin_control_pkg::*; ;
  typedef struct {logic [7:0] v; int s;} note_type;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [PIN_COUNT-1:0] closed = '0;
  logic [PIN_COUNT-1:0] act_hi = 7'h42;
  logic [PIN_COUNT-1:0] pins;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic peek = 1'b0;
  logic pend = 1'b0;
  logic [7:0] reg_rdata_q, adc_attenuation_q, dac_attenuation_q;
  logic [7:0] bypass_attenuation_0_q, bypass_attenuation_1_q;
  logic limiter_force_q, bank_b_active_q, data_clear_q, adc_mute_q, dac_mute_q;
  logic bypass_active_q;
  logic [ROUTE_MSB:0] bypass_route_q;
  note_type notes[$];
  note_type n;
  logic [7:0] obs, d, g0, g1;
  logic [1:0] m;
  int err_total = 0;
  int compares = 0;
  int seed = 67;
  int clears = 0;
  int i;

  always #2.5 clk = ~clk;

  switch_model switch_model_inst (
    .closed(closed),
    .active_high(act_hi),
    .multipurpose_pin(pins)
  );

  multipurpose_pin_control #(.HOLD_CYCLES(20), .REPEAT_CYCLES(5)) multipurpose_pin_control_inst (
    .clk(clk), .reset_n(reset_n), .multipurpose_pin(pins),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata_q(reg_rdata_q), .adc_attenuation_q(adc_attenuation_q),
    .dac_attenuation_q(dac_attenuation_q), .bypass_attenuation_0_q(bypass_attenuation_0_q),
    .bypass_attenuation_1_q(bypass_attenuation_1_q), .limiter_force_q(limiter_force_q),
    .bank_b_active_q(bank_b_active_q), .data_clear_q(data_clear_q), .adc_mute_q(adc_mute_q),
    .dac_mute_q(dac_mute_q), .bypass_active_q(bypass_active_q), .bypass_route_q(bypass_route_q)
  );

  // a note is due one edge after each read or peek
  always @(posedge clk) begin
    pend <= reg_read | peek;
    if (data_clear_q === 1'b1) begin
      clears <= clears + 1;
    end
  end

  // watcher takes the oldest note and compares
  always @(negedge clk) begin
    if (pend) begin
      n = notes.pop_front();
      case (n.s)
        0: obs = reg_rdata_q;
        1: obs = dac_attenuation_q;
        2: obs = bypass_attenuation_0_q;
        3: obs = bypass_attenuation_1_q;
        4: obs = {4'h0, bypass_route_q};
        5: obs = {7'h00, bypass_active_q};
        6: obs = {7'h00, limiter_force_q};
        8: obs = adc_attenuation_q;
        default: obs = clears[7:0];
      endcase
      compares++;
      if (obs !== n.v) begin
        err_total++;
        $display("ERROR %0t source %0d got %h want %h", $time, n.s, obs, n.v);
      end
    end
  end

  task automatic close_out;
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic idle(input int c);
    repeat (c) @(negedge clk);
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_write = 1'b1;
    @(negedge clk);
    reg_write = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    notes.push_back('{e, 0});
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clk);
    reg_read = 1'b0;
    @(negedge clk);
  endtask

  task automatic look(input int s, input logic [7:0] e);
    notes.push_back('{e, s});
    peek = 1'b1;
    @(negedge clk);
    peek = 1'b0;
    @(negedge clk);
  endtask

  // watchdog
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    repeat (12) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    for (i = 0; i < PIN_COUNT; i++) begin
      rd(PIN_FUNCTION_BASE + 16'(i), (i == 1) ? PIN_ONE_RESET : (i == 6) ? PIN_SIX_RESET : PIN_FUNCTION_RESET);
    end
    look(2, 8'hFF);
    look(3, 8'hFF);
    rd(CORE_CONTROL_ADDR, CORE_CONTROL_RESET);
    // every function byte holds any value, then back to reset
    for (i = 0; i < PIN_COUNT; i++) begin
      d = 8'($random(seed));
      wr(PIN_FUNCTION_BASE + 16'(i), d);
      rd(PIN_FUNCTION_BASE + 16'(i), d);
      wr(PIN_FUNCTION_BASE + 16'(i), (i == 1) ? PIN_ONE_RESET : (i == 6) ? PIN_SIX_RESET : PIN_FUNCTION_RESET);
    end
    wr(16'h0070, 8'h5A);
    rd(16'h0070, 8'h00);
    wr(MODE_STATUS_ADDR, 8'hFF);
    rd(MODE_STATUS_ADDR, 8'h00);
    // push-button volume on the adc
    wr(BUTTON_START_ADDR, 8'h40);
    wr(BUTTON_TARGET_ADDR, 8'h01);
    idle(2);
    look(8, 8'h40);
    wr(ADC_VOLUME_ADDR, 8'h11);
    rd(ADC_VOLUME_ADDR, VOLUME_RESET);
    look(8, 8'h40);
    rd(MODE_STATUS_ADDR, 8'h20);
    closed[1] = 1'b1;
    idle(8);
    closed[1] = 1'b0;
    idle(8);
    look(8, 8'h3F);
    closed[6] = 1'b1;
    idle(8);
    closed[6] = 1'b0;
    idle(8);
    look(8, 8'h40);
    closed[1] = 1'b1;
    closed[6] = 1'b1;
    idle(60);
    closed[1] = 1'b0;
    closed[6] = 1'b0;
    idle(8);
    look(8, 8'h40);
    // one button held past the hold time: edge step plus three repeats
    closed[1] = 1'b1;
    idle(40);
    closed[1] = 1'b0;
    idle(8);
    look(8, 8'h3C);
    // limiter pin
    wr(PIN_FUNCTION_BASE + 16'h0002, 8'h03);
    closed[2] = 1'b1;
    look(6, 8'h00);
    idle(6);
    rd(MODE_STATUS_ADDR, 8'h24);
    closed[2] = 1'b0;
    idle(6);
    rd(MODE_STATUS_ADDR, 8'h20);
    // bank pin, software clears the bank field first
    wr(CORE_CONTROL_ADDR, 8'h80);
    wr(PIN_FUNCTION_BASE + 16'h0003, 8'h04);
    idle(6);
    rd(MODE_STATUS_ADDR, 8'h20);
    closed[3] = 1'b1;
    idle(6);
    rd(MODE_STATUS_ADDR, 8'h21);
    look(7, 8'h01);
    wr(CORE_CONTROL_ADDR, 8'h00);
    closed[3] = 1'b0;
    idle(6);
    look(7, 8'h01);
    rd(MODE_STATUS_ADDR, 8'h20);
    // mute pin with each channel choice
    for (i = 1; i < 4; i++) begin
      m = 2'(i);
      wr(PIN_FUNCTION_BASE + 16'h0004, {2'b00, m, 4'h5});
      closed[4] = 1'b1;
      idle(6);
      rd(MODE_STATUS_ADDR, {3'b001, m, 3'b000});
      closed[4] = 1'b0;
      idle(6);
    end
    // bypass pin with random path and gains
    d = 8'($random(seed));
    g0 = 8'hA0 | (8'($random(seed)) & 8'h1F);
    g1 = 8'hA0 | (8'($random(seed)) & 8'h1F);
    wr(BYPASS_PATH_ADDR, d);
    wr(BYPASS_GAIN_0_ADDR, g0);
    wr(BYPASS_GAIN_1_ADDR, g1);
    wr(PIN_FUNCTION_BASE + 16'h0005, 8'h06);
    closed[5] = 1'b1;
    idle(6);
    look(5, 8'h01);
    look(4, {4'h0, d[3:0]});
    idle(52000);
    look(1, MUTE_LEVEL);
    look(2, g0);
    look(3, g1);
    closed[5] = 1'b0;
    idle(6);
    look(4, 8'h00);
    look(5, 8'h00);
    if (notes.size() != 0) begin
      err_total++;
      $display("ERROR %0t notes left unchecked", $time);
    end
    close_out();
  end
endmodule
